// ### verilog/pabmx_top.v
// port a/b alternate pin mux with register port
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "pabmx_consts.vh"
module pabmx_top
#(
  parameter [3:0] ADDR_CYCLES = `PABMX_ADDR_CYCLES
)
(
  input wire clock, // 20 MHz system clock
  input wire rst, // async reset, active high
  input wire ce, // clock enable, low freezes all state
  input wire [`PABMX_AW-1:0] reg_addr, // register address
  input wire [`PABMX_DW-1:0] reg_wdata, // register write data
  input wire reg_wr, // write strobe
  input wire reg_rd, // read strobe
  output reg [`PABMX_DW-1:0] reg_rdata_q, // read data, cycle after strobe
  input wire [7:0] pa_in, // port a pin levels
  output reg [7:0] pa_out_q, // port a driven levels
  output reg [7:0] pa_oe_q, // port a driver enables
  output reg [7:0] pa_pullup_q, // port a pull-up enables
  input wire [7:0] pb_in, // port b pin levels
  output reg [7:0] pb_out_q, // port b driven levels
  output reg [7:0] pb_oe_q, // port b driver enables
  output reg [7:0] pb_pullup_q, // port b pull-up enables
  input wire xm_start, // external memory access start pulse
  input wire xm_wr, // external memory write phase
  input wire [7:0] xm_addr_lo, // low address byte
  input wire [7:0] xm_wdata, // write data
  output reg [7:0] xm_rdata_q, // read data from port a pins
  output reg xm_addr_active_q, // address-active qualifier
  input wire compat_mode, // legacy compatibility strap
  input wire t2_oc, // timer2 compare output
  input wire t2_oc_en, // timer2 compare output enable
  input wire t1_oc_a, // timer1 compare a output
  input wire t1_oc_a_en, // timer1 compare a enable
  input wire t1_oc_b, // timer1 compare b output
  input wire t1_oc_b_en, // timer1 compare b enable
  input wire t1_oc_c, // timer1 compare c output
  input wire t1_oc_c_en, // timer1 compare c enable
  input wire t0_oc, // timer0 compare output
  input wire t0_oc_en, // timer0 compare enable
  input wire spi_en, // spi enabled
  input wire spi_master, // spi in master mode
  input wire spi_mosi_out, // master data out
  input wire spi_sck_out, // master clock out
  input wire spi_slave_out, // slave data out
  output reg spi_miso_in_q, // master data in
  output reg spi_mosi_in_q, // slave data in
  output reg spi_sck_in_q, // slave clock in
  output reg spi_ss_in_q // slave select in
);

////////////////////////////////////////////////////////////////////////////////
// software registers

  reg [7:0] pa_latch_q;
  reg [7:0] pa_dir_q;
  reg [7:0] pb_latch_q;
  reg [7:0] pb_dir_q;
  reg [7:0] sfio_q;
  reg [7:0] muxctl_q;
  wire global_pullup_disable;
  wire xmen;
  wire ada;
  wire [7:0] muxstat;
  reg [7:0] rd_d;

  assign global_pullup_disable = sfio_q[`PABMX_SFIO_PUD];
  assign xmen = muxctl_q[`PABMX_MUXCTL_XMEN];

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pa_latch_q <= `PABMX_RST_BYTE;
      pa_dir_q <= `PABMX_RST_BYTE;
      pb_latch_q <= `PABMX_RST_BYTE;
      pb_dir_q <= `PABMX_RST_BYTE;
      sfio_q <= `PABMX_RST_BYTE;
      muxctl_q <= `PABMX_RST_BYTE;
    end
    else if (ce && reg_wr)
    begin
      if (reg_addr == `PABMX_OFF_PA_LATCH)
      begin
        pa_latch_q <= reg_wdata;
      end
      else if (reg_addr == `PABMX_OFF_PA_DIR)
      begin
        pa_dir_q <= reg_wdata;
      end
      else if (reg_addr == `PABMX_OFF_PB_LATCH)
      begin
        pb_latch_q <= reg_wdata;
      end
      else if (reg_addr == `PABMX_OFF_PB_DIR)
      begin
        pb_dir_q <= reg_wdata;
      end
      else if (reg_addr == `PABMX_OFF_SFIO)
      begin
        // bits 6 and 5 are read-only zero
        sfio_q <= reg_wdata & `PABMX_SFIO_WMASK;
      end
      else if (reg_addr == `PABMX_OFF_MUXCTL)
      begin
        muxctl_q <= reg_wdata & `PABMX_MUXCTL_WMASK;
      end
    end
  end

  assign muxstat = {3'h0, compat_mode, spi_master & spi_en, spi_en, xmen, ada};

  always @*
  begin
    rd_d = `PABMX_RD_NONE;
    if (reg_addr == `PABMX_OFF_PA_LATCH)
    begin
      rd_d = pa_latch_q;
    end
    else if (reg_addr == `PABMX_OFF_PA_DIR)
    begin
      rd_d = pa_dir_q;
    end
    else if (reg_addr == `PABMX_OFF_PA_PINS)
    begin
      rd_d = pa_in;
    end
    else if (reg_addr == `PABMX_OFF_PB_LATCH)
    begin
      rd_d = pb_latch_q;
    end
    else if (reg_addr == `PABMX_OFF_PB_DIR)
    begin
      rd_d = pb_dir_q;
    end
    else if (reg_addr == `PABMX_OFF_PB_PINS)
    begin
      rd_d = pb_in;
    end
    else if (reg_addr == `PABMX_OFF_SFIO)
    begin
      rd_d = sfio_q;
    end
    else if (reg_addr == `PABMX_OFF_MUXCTL)
    begin
      rd_d = muxctl_q;
    end
    else if (reg_addr == `PABMX_OFF_MUXSTAT)
    begin
      rd_d = muxstat;
    end
  end

  // data stand only in the cycle after the strobe, zero elsewhere
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata_q <= `PABMX_RD_NONE;
    end
    else if (ce)
    begin
      reg_rdata_q <= reg_rd ? rd_d : `PABMX_RD_NONE;
    end
  end

////////////////////////////////////////////////////////////////////////////////
// port a: external memory address/data

  pabmx_xmem_seq #(
    .ADDR_CYCLES(ADDR_CYCLES)
  ) u_xmem_seq (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .enable(xmen),
    .start(xm_start),
    .active_q(ada)
  );

  wire pa_bus_drive;
  wire [7:0] pa_oe_d;
  wire [7:0] pa_val_d;
  wire [7:0] pa_pu_d;

  assign pa_bus_drive = xm_wr | ada;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_pa
      // pin gi carries address/data bit gi
      pabmx_pin_cell u_cell (
        .dir_bit(pa_dir_q[gi]),
        .latch_bit(pa_latch_q[gi]),
        .global_pullup_disable(global_pullup_disable),
        .pullup_override_enable(xmen),
        .pullup_override_value(~pa_bus_drive & pa_latch_q[gi] & ~global_pullup_disable),
        .direction_override_enable(xmen),
        .direction_override_value(pa_bus_drive),
        .value_override_enable(xmen),
        .value_override_value(ada ? xm_addr_lo[gi] : xm_wdata[gi]),
        .oe(pa_oe_d[gi]),
        .val(pa_val_d[gi]),
        .pull_en(pa_pu_d[gi])
      );
    end
  endgenerate

////////////////////////////////////////////////////////////////////////////////
// port b: timer compare outputs and spi

  wire spi_mst;
  wire spi_slv;
  wire t1c_ok;
  wire pb7_pick_t1;
  wire [7:0] pb_pullup_override_enable;
  wire [7:0] pb_pullup_override_value;
  wire [7:0] pb_direction_override_enable;
  wire [7:0] pb_direction_override_value;
  wire [7:0] pb_value_override_enable;
  wire [7:0] pb_value_override_value;
  wire [7:0] pb_oe_d;
  wire [7:0] pb_val_d;
  wire [7:0] pb_pu_d;

  assign spi_mst = spi_en & spi_master;
  assign spi_slv = spi_en & ~spi_master;
  assign t1c_ok = t1_oc_c_en & ~compat_mode;

  // timer pins never override pull-up or direction: driver needs dir bit one
  assign pb_pullup_override_enable[7:4] = 4'h0;
  assign pb_pullup_override_value[7:4] = 4'h0;
  assign pb_direction_override_enable[7:4] = 4'h0;
  assign pb_direction_override_value[7:4] = 4'h0;

  // when both bit-7 sources are on and compat mode is off, a control bit picks timer1 over timer2
  assign pb7_pick_t1 = t1c_ok & (muxctl_q[`PABMX_MUXCTL_PB7_T1] | ~t2_oc_en);
  assign pb_value_override_enable[`PABMX_PB_OC7] = t2_oc_en | t1c_ok;
  assign pb_value_override_value[`PABMX_PB_OC7] = pb7_pick_t1 ? t1_oc_c : t2_oc;
  assign pb_value_override_enable[`PABMX_PB_TIMER1_COMPARE_B_OUT] = t1_oc_b_en;
  assign pb_value_override_value[`PABMX_PB_TIMER1_COMPARE_B_OUT] = t1_oc_b;
  assign pb_value_override_enable[`PABMX_PB_TIMER1_COMPARE_A_OUT] = t1_oc_a_en;
  assign pb_value_override_value[`PABMX_PB_TIMER1_COMPARE_A_OUT] = t1_oc_a;
  assign pb_value_override_enable[`PABMX_PB_OC0] = t0_oc_en;
  assign pb_value_override_value[`PABMX_PB_OC0] = t0_oc;

  // miso: input as master, dir bit as slave
  assign pb_pullup_override_enable[`PABMX_PB_MISO] = spi_mst;
  assign pb_pullup_override_value[`PABMX_PB_MISO] = pb_latch_q[`PABMX_PB_MISO] & ~global_pullup_disable;
  assign pb_direction_override_enable[`PABMX_PB_MISO] = spi_mst;
  assign pb_direction_override_value[`PABMX_PB_MISO] = 1'b0;
  assign pb_value_override_enable[`PABMX_PB_MISO] = spi_slv;
  assign pb_value_override_value[`PABMX_PB_MISO] = spi_slave_out;

  // mosi, sck and ss are forced to input as slave
  assign pb_pullup_override_enable[`PABMX_PB_MOSI] = spi_slv;
  assign pb_pullup_override_value[`PABMX_PB_MOSI] = pb_latch_q[`PABMX_PB_MOSI] & ~global_pullup_disable;
  assign pb_direction_override_enable[`PABMX_PB_MOSI] = spi_slv;
  assign pb_direction_override_value[`PABMX_PB_MOSI] = 1'b0;
  assign pb_value_override_enable[`PABMX_PB_MOSI] = spi_mst;
  assign pb_value_override_value[`PABMX_PB_MOSI] = spi_mosi_out;

  assign pb_pullup_override_enable[`PABMX_PB_SCK] = spi_slv;
  assign pb_pullup_override_value[`PABMX_PB_SCK] = pb_latch_q[`PABMX_PB_SCK] & ~global_pullup_disable;
  assign pb_direction_override_enable[`PABMX_PB_SCK] = spi_slv;
  assign pb_direction_override_value[`PABMX_PB_SCK] = 1'b0;
  assign pb_value_override_enable[`PABMX_PB_SCK] = spi_mst;
  assign pb_value_override_value[`PABMX_PB_SCK] = spi_sck_out;

  // ss as master stays a plain port pin
  assign pb_pullup_override_enable[`PABMX_PB_SS] = spi_slv;
  assign pb_pullup_override_value[`PABMX_PB_SS] = pb_latch_q[`PABMX_PB_SS] & ~global_pullup_disable;
  assign pb_direction_override_enable[`PABMX_PB_SS] = spi_slv;
  assign pb_direction_override_value[`PABMX_PB_SS] = 1'b0;
  assign pb_value_override_enable[`PABMX_PB_SS] = 1'b0;
  assign pb_value_override_value[`PABMX_PB_SS] = 1'b0;

  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_pb
      pabmx_pin_cell u_cell (
        .dir_bit(pb_dir_q[gi]),
        .latch_bit(pb_latch_q[gi]),
        .global_pullup_disable(global_pullup_disable),
        .pullup_override_enable(pb_pullup_override_enable[gi]),
        .pullup_override_value(pb_pullup_override_value[gi]),
        .direction_override_enable(pb_direction_override_enable[gi]),
        .direction_override_value(pb_direction_override_value[gi]),
        .value_override_enable(pb_value_override_enable[gi]),
        .value_override_value(pb_value_override_value[gi]),
        .oe(pb_oe_d[gi]),
        .val(pb_val_d[gi]),
        .pull_en(pb_pu_d[gi])
      );
    end
  endgenerate

////////////////////////////////////////////////////////////////////////////////
// output flops: one cycle from control change to pin

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pa_out_q <= `PABMX_RST_BYTE;
      pa_oe_q <= `PABMX_RST_BYTE;
      pa_pullup_q <= `PABMX_RST_BYTE;
      pb_out_q <= `PABMX_RST_BYTE;
      pb_oe_q <= `PABMX_RST_BYTE;
      pb_pullup_q <= `PABMX_RST_BYTE;
      xm_rdata_q <= `PABMX_RST_BYTE;
      xm_addr_active_q <= 1'b0;
    end
    else if (ce)
    begin
      pa_out_q <= pa_val_d;
      pa_oe_q <= pa_oe_d;
      pa_pullup_q <= pa_pu_d;
      pb_out_q <= pb_val_d;
      pb_oe_q <= pb_oe_d;
      pb_pullup_q <= pb_pu_d;
      xm_rdata_q <= pa_in;
      xm_addr_active_q <= ada;
    end
  end

  // spi inputs pass through one flop only; the spi unit adds its own synchroniser
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      spi_miso_in_q <= 1'b0;
      spi_mosi_in_q <= 1'b0;
      spi_sck_in_q <= 1'b0;
      spi_ss_in_q <= 1'b0;
    end
    else if (ce)
    begin
      spi_miso_in_q <= pb_in[`PABMX_PB_MISO];
      spi_mosi_in_q <= pb_in[`PABMX_PB_MOSI];
      spi_sck_in_q <= pb_in[`PABMX_PB_SCK];
      spi_ss_in_q <= pb_in[`PABMX_PB_SS];
    end
  end

endmodule

// ### verilog/pabmx_consts.vh
// constants for the port a/b alternate pin mux
`ifndef PABMX_CONSTS_VH
`define PABMX_CONSTS_VH
`define PABMX_AW 8
`define PABMX_DW 8
`define PABMX_OFF_PA_LATCH 8'h00
`define PABMX_OFF_PA_DIR 8'h01
`define PABMX_OFF_PA_PINS 8'h02
`define PABMX_OFF_PB_LATCH 8'h03
`define PABMX_OFF_PB_DIR 8'h04
`define PABMX_OFF_PB_PINS 8'h05
`define PABMX_OFF_SFIO 8'h06
`define PABMX_OFF_MUXCTL 8'h07
`define PABMX_OFF_MUXSTAT 8'h08
`define PABMX_RST_BYTE 8'h00
`define PABMX_RD_NONE 8'h00
`define PABMX_SFIO_WMASK 8'h9F
`define PABMX_SFIO_PUD 2
`define PABMX_MUXCTL_WMASK 8'h03
`define PABMX_MUXCTL_XMEN 0
`define PABMX_MUXCTL_PB7_T1 1
`define PABMX_ST_ADA 0
`define PABMX_ST_XMEN 1
`define PABMX_ST_SPI_EN 2
`define PABMX_ST_SPI_MSTR 3
`define PABMX_ST_COMPAT 4
`define PABMX_PB_SS 0
`define PABMX_PB_SCK 1
`define PABMX_PB_MOSI 2
`define PABMX_PB_MISO 3
`define PABMX_PB_OC0 4
`define PABMX_PB_TIMER1_COMPARE_A_OUT 5
`define PABMX_PB_TIMER1_COMPARE_B_OUT 6
`define PABMX_PB_OC7 7
`define PABMX_ADDR_CYCLES 4'h1
`endif

// ### verilog/pabmx_pin_cell.v
// one pin's override resolution for pull-up, driver enable and level
`timescale 1ns/1ps
module pabmx_pin_cell
(
  input wire dir_bit, // pin direction bit
  input wire latch_bit, // pin output latch bit
  input wire global_pullup_disable, // global pull-up disable
  input wire pullup_override_enable, // pull-up override enable
  input wire pullup_override_value, // pull-up override value
  input wire direction_override_enable, // direction override enable
  input wire direction_override_value, // direction override value
  input wire value_override_enable, // value override enable
  input wire value_override_value, // value override value
  output wire oe, // output driver on
  output wire val, // driven level
  output wire pull_en // pull-up on
);
  assign oe = direction_override_enable ? direction_override_value : dir_bit;
  // level only matters while driving; parked at latch otherwise
  assign val = (value_override_enable && oe) ? value_override_value : latch_bit;
  assign pull_en = pullup_override_enable ? pullup_override_value : (~dir_bit & latch_bit & ~global_pullup_disable);
endmodule

// ### verilog/pabmx_xmem_seq.v
// address-phase qualifier for the multiplexed external memory bus
`timescale 1ns/1ps
`include "pabmx_consts.vh"
module pabmx_xmem_seq
#(
  parameter [3:0] ADDR_CYCLES = `PABMX_ADDR_CYCLES
)
(
  input wire clock, // system clock
  input wire rst, // async reset, active high
  input wire ce, // clock enable
  input wire enable, // external memory enabled
  input wire start, // access start pulse
  output reg active_q // address-active qualifier
);
  reg [3:0] cnt_q;
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      active_q <= 1'b0;
      cnt_q <= 4'h0;
    end
    else if (ce)
    begin
      if (!enable)
      begin
        active_q <= 1'b0;
        cnt_q <= 4'h0;
      end
      else if (start)
      begin
        active_q <= 1'b1;
        cnt_q <= ADDR_CYCLES;
      end
      else if (cnt_q > 4'h1)
      begin
        cnt_q <= cnt_q - 4'h1;
      end
      else
      begin
        active_q <= 1'b0;
        cnt_q <= 4'h0;
      end
    end
  end
endmodule

// ### tb/pabmx_asserts.sv
// concurrent checks on the pin mux top ports
`timescale 1ns/1ps
`include "pabmx_consts.vh"
module pabmx_asserts
#(
  parameter [3:0] ADDR_CYCLES = `PABMX_ADDR_CYCLES
)
(
  input logic clock, // clock
  input logic rst, // async reset
  input logic ce, // clock enable
  input logic [7:0] reg_addr, // address
  input logic [7:0] reg_wdata, // write data
  input logic reg_wr, // write strobe
  input logic [7:0] pa_out_q, // port a level
  input logic [7:0] pa_oe_q, // port a drive
  input logic [7:0] pa_pullup_q, // port a pull-up
  input logic [7:0] pb_out_q, // port b level
  input logic [7:0] pb_oe_q, // port b drive
  input logic [7:0] pb_pullup_q, // port b pull-up
  input logic xm_start, // access start
  input logic xm_wr, // write phase
  input logic [7:0] xm_addr_lo, // address byte
  input logic [7:0] xm_wdata, // write data
  input logic xm_addr_active_q, // address qualifier
  input logic compat_mode, // legacy mode
  input logic t2_oc, // timer2 out
  input logic t2_oc_en, // timer2 enable
  input logic t1_oc_c_en, // timer1 c enable
  input logic t1_oc_b, // timer1 b out
  input logic t1_oc_b_en, // timer1 b enable
  input logic spi_en, // spi on
  input logic spi_master, // spi master
  input logic spi_mosi_out, // master data
  input logic spi_slave_out // slave data
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0] pa_lat_q, pb_lat_q, pb_dir_q;
  logic pud_q, xmen_q;
  logic [3:0] run_q;
  // shadow of the port a/b latches, port b direction, pull-up disable and xmen bits
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      {pa_lat_q, pb_lat_q, pb_dir_q, pud_q, xmen_q} <= '0;
    end
    else if (ce && reg_wr)
    begin
      case (reg_addr)
        `PABMX_OFF_PA_LATCH: pa_lat_q <= reg_wdata;
        `PABMX_OFF_PB_LATCH: pb_lat_q <= reg_wdata;
        `PABMX_OFF_PB_DIR: pb_dir_q <= reg_wdata;
        `PABMX_OFF_SFIO: pud_q <= reg_wdata[2];
        `PABMX_OFF_MUXCTL: xmen_q <= reg_wdata[0];
        default: ;
      endcase
    end
  end
  // length of the current address phase
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      run_q <= 4'h0;
    else if (ce)
      run_q <= xm_addr_active_q ? run_q + 4'h1 : 4'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_start;
    xm_start && xmen_q;
  endsequence
  sequence s_addr_out;
    xm_addr_active_q && pa_oe_q == 8'hFF;
  endsequence
  start_to_qual_a: assert property (s_start |-> ##[1:3] s_addr_out)
    else $error("address phase did not follow start");
  addr_len_a: assert property ($fell(xm_addr_active_q) |-> run_q == ADDR_CYCLES)
    else $error("address phase length wrong");
  addr_drive_a: assert property (xm_addr_active_q |-> pa_oe_q == 8'hFF && pa_out_q == $past(xm_addr_lo))
    else $error("address not on port a");
  wr_drive_a: assert property ($past(xmen_q && xm_wr) && !xm_addr_active_q |-> pa_oe_q == 8'hFF && pa_out_q == $past(xm_wdata))
    else $error("write data not on port a");
  xm_idle_a: assert property ($past(xmen_q && !xm_wr) && !xm_addr_active_q
    |-> pa_oe_q == 8'h00 && pa_pullup_q == $past(pa_lat_q & {8{!pud_q}}))
    else $error("idle port a wrong");
  pud_all_off_a: assert property ($past(pud_q) |-> pa_pullup_q == 8'h00 && pb_pullup_q == 8'h00)
    else $error("pull-up on while disabled");
  pb6_timer_a: assert property ($past(pb_dir_q[6] && t1_oc_b_en) |-> pb_oe_q[6] && pb_out_q[6] == $past(t1_oc_b))
    else $error("pb6 compare output wrong");
  pb7_timer_a: assert property ($past(pb_dir_q[7] && t2_oc_en && !t1_oc_c_en) |-> pb_out_q[7] == $past(t2_oc))
    else $error("pb7 timer2 output wrong");
  pb7_compat_a: assert property ($past(pb_dir_q[7] && compat_mode && t1_oc_c_en && !t2_oc_en)
    |-> pb_out_q[7] == $past(pb_lat_q[7]))
    else $error("pb7 carries compare c in legacy mode");
  miso_master_a: assert property ($past(spi_en && spi_master) |-> !pb_oe_q[3] && pb_pullup_q[3] == $past(pb_lat_q[3]
    && !pud_q) && (!pb_oe_q[2] || pb_out_q[2] == $past(spi_mosi_out)))
    else $error("spi master pins wrong");
  miso_slave_a: assert property ($past(spi_en && !spi_master) |-> pb_oe_q[3:0] == {$past(pb_dir_q[3]), 3'h0}
    && (!pb_oe_q[3] || pb_out_q[3] == $past(spi_slave_out)))
    else $error("spi slave pins wrong");
  pb_plain_a: assert property ($past(!spi_en) |-> pb_pullup_q == $past(~pb_dir_q & pb_lat_q & {8{!pud_q}})
    && pb_oe_q == $past(pb_dir_q) && pb_out_q[3:0] == $past(pb_lat_q[3:0]))
    else $error("plain port b pin wrong");
endmodule
bind pabmx_top pabmx_asserts #(.ADDR_CYCLES(ADDR_CYCLES)) pabmx_asserts_inst (.clock, .rst, .ce, .reg_addr,
  .reg_wdata, .reg_wr, .pa_out_q, .pa_oe_q, .pa_pullup_q, .pb_out_q, .pb_oe_q, .pb_pullup_q, .xm_start, .xm_wr,
  .xm_addr_lo, .xm_wdata, .xm_addr_active_q, .compat_mode, .t2_oc, .t2_oc_en, .t1_oc_c_en, .t1_oc_b, .t1_oc_b_en,
  .spi_en, .spi_master, .spi_mosi_out, .spi_slave_out);

// ### tb/pabmx_partner.sv
// external memory and spi devices seen at the pins
`timescale 1ns/1ps
module pabmx_partner
(
  input logic clock, // clock
  input logic [7:0] pa_out_q, // port a level
  input logic [7:0] pa_oe_q, // port a drive
  input logic [7:0] pa_pullup_q, // port a pull-up
  input logic xm_addr_active_q, // address phase
  input logic mem_rd, // memory drives data
  input logic [7:0] pb_out_q, // port b level
  input logic [7:0] pb_oe_q, // port b drive
  input logic [7:0] pb_pullup_q, // port b pull-up
  input logic [7:0] pb_ext, // far-side level
  input logic [7:0] pb_ext_en, // far-side drive
  output logic [7:0] pa_in, // port a wire
  output logic [7:0] pb_in // port b wire
);
  logic [7:0] addr_q = 8'h00;
  logic [7:0] last_a = 8'h00;
  logic [7:0] last_b = 8'h00;
  // undriven lines with no pull-up and no memory or far-side drive flip each cycle so stale values never look valid
  assign pa_in = (pa_oe_q & pa_out_q) | (~pa_oe_q & (mem_rd ? ~addr_q : pa_pullup_q | ~last_a));
  assign pb_in = (pb_oe_q & pb_out_q) | (~pb_oe_q & ((pb_ext_en & pb_ext) | (~pb_ext_en & (pb_pullup_q | ~last_b))));
  always @(posedge clock)
  begin
    last_a <= pa_in;
    last_b <= pb_in;
    if (xm_addr_active_q && pa_oe_q == 8'hFF)
      addr_q <= pa_in;
  end
endmodule

// ### tb/pabmx_top_tb.sv
// self-checking bench for the port a/b pin mux
`timescale 1ns/1ps
`include "pabmx_consts.vh"
module pabmx_top_tb;
  localparam [3:0] ACYC = 4'h2;
  logic clock, rst, ce, reg_wr, reg_rd, xm_start, xm_wr, compat_mode, mem_rd, t2_oc, t2_oc_en, t1_oc_a, t1_oc_a_en;
  logic t1_oc_b, t1_oc_b_en, t1_oc_c, t1_oc_c_en, t0_oc, t0_oc_en, spi_en, spi_master, spi_mosi_out, spi_sck_out;
  logic spi_slave_out;
  logic [7:0] reg_addr, reg_wdata, xm_addr_lo, xm_wdata, pb_ext, pb_ext_en;
  wire [7:0] reg_rdata_q, pa_in, pa_out_q, pa_oe_q, pa_pullup_q, pb_in, pb_out_q, pb_oe_q, pb_pullup_q, xm_rdata_q;
  wire xm_addr_active_q, spi_miso_in_q, spi_mosi_in_q, spi_sck_in_q, spi_ss_in_q;
  int mismatches = 0;
  int checked = 0;
  int i, n;
  // pb7 rows: t2 en, t1c en, compat, prefer t1c, t2 out, t1c out, expected pin
  logic [6:0] pb7_tab [6] = '{7'h45, 7'h23, 7'h32, 7'h7A, 7'h62, 7'h6C};
  pabmx_top #(.ADDR_CYCLES(ACYC)) pabmx_top_inst (.clock, .rst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_q, .pa_in, .pa_out_q, .pa_oe_q, .pa_pullup_q, .pb_in, .pb_out_q, .pb_oe_q, .pb_pullup_q, .xm_start,
    .xm_wr, .xm_addr_lo, .xm_wdata, .xm_rdata_q, .xm_addr_active_q, .compat_mode, .t2_oc, .t2_oc_en, .t1_oc_a,
    .t1_oc_a_en, .t1_oc_b, .t1_oc_b_en, .t1_oc_c, .t1_oc_c_en, .t0_oc, .t0_oc_en, .spi_en, .spi_master,
    .spi_mosi_out, .spi_sck_out, .spi_slave_out, .spi_miso_in_q, .spi_mosi_in_q, .spi_sck_in_q, .spi_ss_in_q);
  pabmx_partner pabmx_partner_inst (.clock, .pa_out_q, .pa_oe_q, .pa_pullup_q, .xm_addr_active_q, .mem_rd,
    .pb_out_q, .pb_oe_q, .pb_pullup_q, .pb_ext, .pb_ext_en, .pa_in, .pb_in);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata_q, exp);
  endtask
  // pins are registered once more after the register edge
  task automatic settle;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic print_verdict;
    if (mismatches == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial
  begin
    repeat (3000) @(posedge clock);
    mismatches++;
    print_verdict;
  end
  initial
  begin
    {rst, ce} = 2'h3;
    {reg_wr, reg_rd, xm_start, xm_wr, compat_mode, mem_rd, t2_oc, t2_oc_en, t1_oc_a, t1_oc_a_en} = '0;
    {t1_oc_b, t1_oc_b_en, t1_oc_c, t1_oc_c_en, t0_oc, t0_oc_en, spi_en, spi_master, spi_mosi_out} = '0;
    {spi_sck_out, spi_slave_out, reg_addr, reg_wdata, xm_addr_lo, xm_wdata, pb_ext, pb_ext_en} = '0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rd(`PABMX_OFF_SFIO, 8'h00);
    wr(`PABMX_OFF_SFIO, 8'hFF);
    rd(`PABMX_OFF_SFIO, 8'h9F);
    wr(8'h20, 8'h55);
    rd(8'h20, 8'h00);
    wr(`PABMX_OFF_SFIO, 8'h00);
    wr(`PABMX_OFF_PB_DIR, 8'h0F);
    wr(`PABMX_OFF_PB_LATCH, 8'hF0);
    wr(`PABMX_OFF_PA_LATCH, 8'hFF);
    settle;
    chk(pb_pullup_q, 8'hF0);
    chk(pb_oe_q, 8'h0F);
    chk(pb_out_q, 8'hF0);
    chk(pa_pullup_q, 8'hFF);
    wr(`PABMX_OFF_SFIO, 8'h04);
    settle;
    chk(pb_pullup_q, 8'h00);
    chk(pa_pullup_q, 8'h00);
    wr(`PABMX_OFF_SFIO, 8'h00);
    wr(`PABMX_OFF_PB_DIR, 8'hF0);
    wr(`PABMX_OFF_PB_LATCH, 8'h00);
    @(posedge clock);
    {t0_oc, t0_oc_en, t1_oc_a, t1_oc_a_en, t1_oc_b, t1_oc_b_en} <= 6'h3F;
    settle;
    chk(pb_out_q, 8'h70);
    chk(pb_oe_q, 8'hF0);
    for (i = 0; i < 6; i++)
    begin
      wr(`PABMX_OFF_MUXCTL, {6'h00, pb7_tab[i][3], 1'b0});
      @(posedge clock);
      {t2_oc_en, t1_oc_c_en, compat_mode} <= pb7_tab[i][6:4];
      {t2_oc, t1_oc_c} <= pb7_tab[i][2:1];
      settle;
      chk({7'h00, pb_out_q[7]}, {7'h00, pb7_tab[i][0]});
    end
    wr(`PABMX_OFF_PB_DIR, 8'h00);
    settle;
    chk(pb_out_q, 8'h00);
    wr(`PABMX_OFF_PB_DIR, 8'h0F);
    wr(`PABMX_OFF_PB_LATCH, 8'h08);
    @(posedge clock);
    {compat_mode, spi_en, spi_master, spi_mosi_out, spi_sck_out} <= 5'h0E;
    pb_ext <= 8'h08;
    pb_ext_en <= 8'h08;
    settle;
    chk(pb_oe_q, 8'h07);
    chk(pb_pullup_q, 8'h08);
    chk(pb_out_q & 8'h07, 8'h04);
    chk({7'h00, spi_miso_in_q}, 8'h01);
    rd(`PABMX_OFF_MUXSTAT, 8'h0C);
    @(posedge clock);
    spi_master <= 1'b0;
    spi_slave_out <= 1'b1;
    pb_ext <= 8'h05;
    pb_ext_en <= 8'h07;
    settle;
    chk(pb_oe_q, 8'h08);
    chk(pb_out_q & 8'h08, 8'h08);
    chk({5'h00, spi_mosi_in_q, spi_sck_in_q, spi_ss_in_q}, 8'h05);
    wr(`PABMX_OFF_PB_DIR, 8'h07);
    settle;
    chk(pb_oe_q, 8'h00);
    @(posedge clock);
    spi_en <= 1'b0;
    wr(`PABMX_OFF_PA_LATCH, 8'h0F);
    wr(`PABMX_OFF_MUXCTL, 8'h01);
    @(posedge clock);
    xm_addr_lo <= 8'hA5;
    xm_start <= 1'b1;
    @(posedge clock);
    xm_start <= 1'b0;
    for (n = 0; xm_addr_active_q !== 1'b1 && n < 10; n++)
    begin
      @(posedge clock);
      #1;
    end
    chk(pa_out_q, 8'hA5);
    chk(pa_oe_q, 8'hFF);
    for (n = 0; xm_addr_active_q === 1'b1 && n < 20; n++)
    begin
      @(posedge clock);
      #1;
    end
    chk(8'(n), 8'(ACYC));
    @(posedge clock);
    xm_wr <= 1'b1;
    xm_wdata <= 8'h3C;
    settle;
    chk(pa_out_q, 8'h3C);
    chk(pa_pullup_q, 8'h00);
    @(posedge clock);
    xm_wr <= 1'b0;
    mem_rd <= 1'b1;
    settle;
    chk(pa_oe_q, 8'h00);
    chk(pa_pullup_q, 8'h0F);
    chk(xm_rdata_q, 8'h5A);
    wr(`PABMX_OFF_SFIO, 8'h04);
    settle;
    chk(pa_pullup_q, 8'h00);
    // a write while ce is low must not clear the pull-up disable
    @(posedge clock);
    ce <= 1'b0;
    wr(`PABMX_OFF_SFIO, 8'h00);
    ce <= 1'b1;
    settle;
    chk(pa_pullup_q, 8'h00);
    print_verdict;
  end
endmodule
